// ---- inc/cswfs_pkg.sv ----
// Purpose: shared types of the clock switch block
// Assumes: nothing
// Notes: constants live in cswfs_regs.svh
package cswfs_pkg;
  typedef enum logic [2:0] {SEQ_POR, SEQ_POWERUP_TIMER, SEQ_HOLD, SEQ_QSYNC, SEQ_RUN} cswfs_seq_t;
  // raw oscillator and reset pins, sampled through synchronisers
  typedef struct packed {
    logic ext_reset_pin_n;
    logic brownout;
    logic osc_fail;
    logic osc_running;
    logic osc_startup_done;
    logic pll_lock;
  } cswfs_pins_t;
  // fuses and core events on this clock
  typedef struct packed {
    logic [2:0] osc_source_cfg;
    logic [3:0] primary_osc_cfg;
    logic [1:0] switch_monitor_cfg;
    logic [1:0] powerup_cfg;
    logic wdt_cfg_en;
  } cswfs_cfg_t;
  typedef struct packed {
    logic sleep;
    logic wdt_timeout;
    logic reset_instr;
    logic trap_lockup;
    logic illegal_op;
  } cswfs_core_t;
endpackage

// ---- inc/cswfs_regs.svh ----
// Purpose: register map, field positions and timing counts of the clock switch block
// Assumes: 100 MHz clock, AXI4-Lite word registers
// Notes: definitions only
`ifndef CSWFS_REGS_SVH
`define CSWFS_REGS_SVH
// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define CSWFS_OSC_CTRL_OFS 8'h00
`define CSWFS_CAUSE_OFS 8'h04
`define CSWFS_MISC_OFS 8'h08
// ------------------------------------------------------------
// oscillator control fields
// ------------------------------------------------------------
`define CSWFS_SWEN_BIT 0
`define CSWFS_CF_BIT 3
`define CSWFS_LOCK_BIT 5
`define CSWFS_NEW_LSB 8
`define CSWFS_CUR_LSB 12
`define CSWFS_KEY_LO1 8'h46
`define CSWFS_KEY_LO2 8'h57
`define CSWFS_KEY_HI1 8'h78
`define CSWFS_KEY_HI2 8'h9a
// ------------------------------------------------------------
// oscillator group codes and timing
// ------------------------------------------------------------
`define CSWFS_GRP_FAST 2'h1
`define CSWFS_GRP_SLOW 2'h2
`define CSWFS_CLK_NS 10
`define CSWFS_POR_NS 10000
`define CSWFS_POR_CYC ((`CSWFS_POR_NS + `CSWFS_CLK_NS - 1) / `CSWFS_CLK_NS)
`define CSWFS_MS_CYC (1000000 / `CSWFS_CLK_NS)
`define CSWFS_PWRT1_CYC (4 * `CSWFS_MS_CYC)
`define CSWFS_PWRT2_CYC (16 * `CSWFS_MS_CYC)
`define CSWFS_PWRT3_CYC (64 * `CSWFS_MS_CYC)
`define CSWFS_FILT_CYC 8
`define CSWFS_SWITCH_CYC 4
`endif

// ---- logic/cswfs_top.sv ----
// Purpose: clock group switching, fail-safe monitor and power-up reset sequencing
// Assumes: 100 MHz clk_i; AXI4-Lite slave; fuses static after reset
// Notes: raw pins are synchronised here
// Functional notes
// [R1] slow osc on at power-up; after timer kept only for monitor, watchdog or selection
// [R2] monitor enabled: slow osc runs except Sleep, soft watchdog bit ignored
// [R3] oscillator failure raises trap and moves clock to fast internal osc
// [R4] failure loads fast group, sets fail flag bit 3, clears switch enable bit 0
// [R5] failure leaves watchdog on slow osc untouched
// [R6] monitor on: clock not ready at timer expiry gives trap and fast osc
// [R7] four groups; switch only between groups; primary choice from primary config
// [R8] read-only current group field; software writes separate new group field
// [R9] power-on and brown-out load current and new group from source config
// [R10] read-only PLL lock and clock fail status bits
// [R11] switch starts when enable set; clearing enable aborts transition
// [R12] switch/monitor config 1x disables switching and monitor
// [R13] switching disabled: config selects clock; current field only reports
// [R14] software avoids clocks below 100 kHz with monitor on
// [R15] low byte writable only after 0x46 then 0x57, for one write
// [R16] high byte writable only after 0x78 then 0x9a, for one write
// [R17] reset causes recorded in readable status bits
// [R18] watchdog wake-up from Sleep is no reset
// [R19] external reset pin filtered; internal resets never drive it
// [R20] power-on delay, then power-up delay, release on first quadrature phase
// [R21] no monitor and no timer: leave reset at once
// [R22] no monitor and no clock: stay in reset until clock appears
`timescale 1ns/1ps
`include "cswfs_regs.svh"

module cswfs_top import cswfs_pkg::*; #(
  parameter int unsigned PWRT1_CYC = `CSWFS_PWRT1_CYC,
  parameter int unsigned PWRT2_CYC = `CSWFS_PWRT2_CYC,
  parameter int unsigned PWRT3_CYC = `CSWFS_PWRT3_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire cswfs_pins_t pins_i,
  input wire cswfs_cfg_t cfg_i,
  input wire cswfs_core_t core_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic system_reset_o,
  output logic slow_osc_en_o,
  output logic [1:0] sys_clk_grp_o,
  output logic [3:0] primary_sel_o,
  output logic clock_fail_trap_o
);

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  typedef struct packed {
    cswfs_pins_t s1;
    cswfs_pins_t s2;
    cswfs_seq_t seq;
    logic [23:0] cnt;
    logic [1:0] q;
    logic [1:0] cur;
    logic [1:0] nsel;
    logic cf;
    logic swen;
    logic [3:0] swcnt;
    logic [1:0] unlo;
    logic [1:0] unhi;
    logic [7:0] cause;
    logic soft_wdt;
    logic [3:0] filt;
    logic pin_low;
    logic sys_rst;
    logic slow_en;
    logic [1:0] grp;
    logic [3:0] prim;
    logic trap;
    logic aw_ok;
    logic [7:0] aw_addr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awrdy;
    logic wrdy;
    logic ardy;
  } cswfs_state_t;

  cswfs_state_t r;
  cswfs_state_t next_r;
  logic [1:0] rst_sync;
  logic rstn;
  logic failsafe_monitor_en;
  logic sw_en_cfg;
  logic [23:0] powerup_timer_lim;
  logic not_ready;
  logic reset_evt;

  // reset released through two flip-flops
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rstn = rst_sync[1];

  // [R12] config decode
  assign sw_en_cfg = !cfg_i.switch_monitor_cfg[1];
  assign failsafe_monitor_en = (cfg_i.switch_monitor_cfg == 2'h0);
  assign not_ready = !r.s2.osc_running || !r.s2.osc_startup_done || !r.s2.pll_lock;
  // [R18] watchdog timeout in Sleep is only a wake-up
  assign reset_evt = (core_i.wdt_timeout && !core_i.sleep) || core_i.reset_instr
                     || core_i.trap_lockup || core_i.illegal_op;

  // [R20] power-up delay chosen by fuse
  always_comb begin
    case (cfg_i.powerup_cfg)
      2'h1: powerup_timer_lim = 24'(PWRT1_CYC);
      2'h2: powerup_timer_lim = 24'(PWRT2_CYC);
      2'h3: powerup_timer_lim = 24'(PWRT3_CYC);
      default: powerup_timer_lim = 24'h0;
    endcase
  end

  // ----------------------------------------------------------
  // next state
  // ----------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.trap = 1'b0;
    // pins pass two flops; only s2 is looked at
    next_r.s1 = pins_i;
    next_r.s2 = r.s1;
    next_r.q = r.q + 2'h1;
    // [R19] pin noise filter, a pulse shorter than the filter is dropped
    if (r.s2.ext_reset_pin_n) begin
      next_r.filt = 4'h0;
      next_r.pin_low = 1'b0;
    end else if (r.filt == 4'(`CSWFS_FILT_CYC)) begin
      next_r.pin_low = 1'b1;
    end else begin
      next_r.filt = r.filt + 4'h1;
    end
    // sequencer
    case (r.seq)
      SEQ_POR: begin
        // [R9] groups loaded from source config on power-on and brown-out
        next_r.cur = cfg_i.osc_source_cfg[1:0];
        next_r.nsel = cfg_i.osc_source_cfg[1:0];
        next_r.swen = 1'b0;
        next_r.cnt = r.cnt + 24'h1;
        // [R20] fixed power-on delay
        if (r.cnt >= 24'(`CSWFS_POR_CYC - 1)) begin
          next_r.cnt = 24'h0;
          next_r.seq = SEQ_POWERUP_TIMER;
        end
      end
      SEQ_POWERUP_TIMER: begin
        next_r.cnt = r.cnt + 24'h1;
        // [R21] zero power-up delay falls through at once
        if (r.cnt >= powerup_timer_lim) begin
          next_r.cnt = 24'h0;
          next_r.seq = SEQ_QSYNC;
        end
      end
      SEQ_HOLD: begin
        if (!r.pin_low) begin
          next_r.seq = SEQ_QSYNC;
        end
      end
      SEQ_QSYNC: begin
        // [R22] frozen until a clock appears when the monitor is off
        // [R20] release lines up with the first quadrature phase
        if (r.q == 2'h3 && (failsafe_monitor_en || r.s2.osc_running)) begin
          next_r.sys_rst = 1'b0;
          next_r.seq = SEQ_RUN;
          // [R6] clock still not ready when the timers end
          if (failsafe_monitor_en && not_ready) begin
            next_r.trap = 1'b1;
            next_r.cur = `CSWFS_GRP_FAST;
            next_r.cf = 1'b1;
            next_r.swen = 1'b0;
          end
        end
      end
      SEQ_RUN: begin
        // [R11] switch runs while enable stays set; clearing it aborts
        if (r.swen && sw_en_cfg) begin
          next_r.swcnt = r.swcnt + 4'h1;
          if (r.swcnt == 4'(`CSWFS_SWITCH_CYC)) begin
            // [R7] only the group changes hands
            next_r.cur = r.nsel;
            next_r.swen = 1'b0;
            next_r.swcnt = 4'h0;
          end
        end else begin
          next_r.swcnt = 4'h0;
        end
        // [R3] failure moves the clock to the fast group
        // [R4] fast code, fail flag set, switch enable cleared
        if (failsafe_monitor_en && r.s2.osc_fail && r.cur != `CSWFS_GRP_FAST) begin
          next_r.trap = 1'b1;
          next_r.cur = `CSWFS_GRP_FAST;
          next_r.cf = 1'b1;
          next_r.swen = 1'b0;
          next_r.swcnt = 4'h0;
        end
      end
      default: next_r.seq = SEQ_POR;
    endcase
    // ----------------------------------------------------------
    // AXI4-Lite slave, one write and one read in flight
    // ----------------------------------------------------------
    if (s_axi_awvalid && r.awrdy) begin
      next_r.aw_ok = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wrdy) begin
      next_r.w_ok = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.aw_ok && r.w_ok) begin
      next_r.aw_ok = 1'b0;
      next_r.w_ok = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = 2'h0;
      // any write other than the key steps closes both locks
      next_r.unlo = 2'h0;
      next_r.unhi = 2'h0;
      case (r.aw_addr)
        `CSWFS_OSC_CTRL_OFS: begin
          // [R15] low byte: key pair, then one write
          if (r.wstrb[0]) begin
            if (r.unlo == 2'h2) begin
              next_r.swen = r.wdata[`CSWFS_SWEN_BIT] && r.seq == SEQ_RUN && !next_r.trap;
            end else if (r.unlo == 2'h1 && r.wdata[7:0] == `CSWFS_KEY_LO2) begin
              next_r.unlo = 2'h2;
            end else if (r.wdata[7:0] == `CSWFS_KEY_LO1) begin
              next_r.unlo = 2'h1;
            end
          end
          // [R16] high byte: key pair, then one write
          if (r.wstrb[1]) begin
            if (r.unhi == 2'h2) begin
              // [R8] only the new group is writable
              next_r.nsel = r.wdata[`CSWFS_NEW_LSB +: 2];
            end else if (r.unhi == 2'h1 && r.wdata[15:8] == `CSWFS_KEY_HI2) begin
              next_r.unhi = 2'h2;
            end else if (r.wdata[15:8] == `CSWFS_KEY_HI1) begin
              next_r.unhi = 2'h1;
            end
          end
        end
        `CSWFS_CAUSE_OFS: begin
          if (r.wstrb[0]) begin
            next_r.cause = r.wdata[7:0];
          end
        end
        `CSWFS_MISC_OFS: begin
          if (r.wstrb[0]) begin
            next_r.soft_wdt = r.wdata[0];
          end
        end
        default: next_r.bresp = 2'h2;
      endcase
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r.ardy) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = 2'h0;
      next_r.rdata = 32'h0;
      case (s_axi_araddr)
        // [R10] lock and fail status read back
        `CSWFS_OSC_CTRL_OFS: begin
          next_r.rdata[`CSWFS_CUR_LSB +: 2] = r.cur;
          next_r.rdata[`CSWFS_NEW_LSB +: 2] = r.nsel;
          next_r.rdata[`CSWFS_LOCK_BIT] = r.s2.pll_lock;
          next_r.rdata[`CSWFS_CF_BIT] = r.cf;
          next_r.rdata[`CSWFS_SWEN_BIT] = r.swen;
        end
        `CSWFS_CAUSE_OFS: next_r.rdata[7:0] = r.cause;
        `CSWFS_MISC_OFS: begin
          next_r.rdata[3:0] = {r.sys_rst, r.slow_en, failsafe_monitor_en, r.soft_wdt};
        end
        default: next_r.rresp = 2'h2;
      endcase
    end
    // [R17] causes set after software writes so a set wins
    if (r.s2.brownout) begin
      next_r.cause[0] = 1'b1;
      next_r.seq = SEQ_POR;
      next_r.cnt = 24'h0;
      next_r.sys_rst = 1'b1;
    end else if ((r.pin_low && !r.sys_rst) || reset_evt) begin
      next_r.cause[5] = next_r.cause[5] | r.pin_low;
      next_r.cause[2] = next_r.cause[2] | (r.pin_low && core_i.sleep);
      next_r.cause[3] = next_r.cause[3] | core_i.wdt_timeout;
      next_r.cause[4] = next_r.cause[4] | core_i.reset_instr;
      next_r.cause[7] = next_r.cause[7] | core_i.trap_lockup;
      next_r.cause[6] = next_r.cause[6] | core_i.illegal_op;
      next_r.seq = SEQ_HOLD;
      next_r.sys_rst = 1'b1;
    end else if (core_i.wdt_timeout && core_i.sleep) begin
      // [R18] wake-up flags only
      next_r.cause[3] = 1'b1;
      next_r.cause[2] = 1'b1;
    end
    // [R1] [R2] slow osc on in reset, then only while needed
    // [R5] a failure never removes the watchdog's clock
    if (next_r.seq != SEQ_RUN) begin
      next_r.slow_en = 1'b1;
    end else if (failsafe_monitor_en) begin
      next_r.slow_en = !core_i.sleep;
    end else begin
      next_r.slow_en = cfg_i.wdt_cfg_en || r.soft_wdt || next_r.cur == `CSWFS_GRP_SLOW;
    end
    // [R13] with switching off the fuses pick the clock directly
    if (!sw_en_cfg) begin
      next_r.cur = cfg_i.osc_source_cfg[1:0];
    end
    next_r.grp = next_r.cur;
    // [R7] primary choice always from primary config
    next_r.prim = cfg_i.primary_osc_cfg;
    // readies kept in flops so every port comes from one
    next_r.awrdy = !next_r.aw_ok && !next_r.bvalid;
    next_r.wrdy = !next_r.w_ok && !next_r.bvalid;
    next_r.ardy = !next_r.rvalid;
  end

  // state register; clock enable freezes everything
  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.seq <= SEQ_POR;
      r.cause <= 8'h03;
      r.sys_rst <= 1'b1;
      r.slow_en <= 1'b1;
      r.s1 <= 6'h20;
      r.s2 <= 6'h20;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------
  // outputs straight from flops
  // ----------------------------------------------------------
  assign s_axi_awready = r.awrdy;
  assign s_axi_wready = r.wrdy;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.ardy;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign system_reset_o = r.sys_rst;
  assign slow_osc_en_o = r.slow_en;
  assign sys_clk_grp_o = r.grp;
  assign primary_sel_o = r.prim;
  assign clock_fail_trap_o = r.trap;

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn || !ce_i);

  fail_loads_fast_a: assert property ( // [R4]
    r.trap |-> r.cur == `CSWFS_GRP_FAST && r.cf && !r.swen) else $error("fail update wrong");
  trap_monitor_only_a: assert property ( // [R3]
    r.trap |-> failsafe_monitor_en) else $error("trap without monitor");
  slow_in_reset_a: assert property ( // [R1]
    r.sys_rst |-> slow_osc_en_o) else $error("slow osc off in reset");
  slow_monitor_on_a: assert property ( // [R2]
    ##1 (r.seq == SEQ_RUN && $past(r.seq) == SEQ_RUN && failsafe_monitor_en && !core_i.sleep
    && $stable(core_i.sleep)) |-> ##1 slow_osc_en_o) else $error("slow osc stopped");
  release_phase_a: assert property ( // [R20]
    $fell(r.sys_rst) |-> r.q == 2'h0) else $error("release off phase");
  frozen_no_clock_a: assert property ( // [R22]
    (r.seq == SEQ_QSYNC && !failsafe_monitor_en && !r.s2.osc_running) |=> r.sys_rst)
    else $error("left reset without clock");
  fixed_cfg_grp_a: assert property ( // [R13]
    (!sw_en_cfg && $stable(cfg_i)) [*3] |-> sys_clk_grp_o == cfg_i.osc_source_cfg[1:0])
    else $error("group not from fuses");
  abort_switch_a: assert property ( // [R11]
    (r.seq == SEQ_RUN && !r.swen) |=> $stable(r.cur) || r.trap || !sw_en_cfg)
    else $error("switch without enable");
  key_open_lo_a: assert property ( // [R15]
    (r.unlo == 2'h2 && r.aw_ok && r.w_ok) |=> r.unlo == 2'h0) else $error("low lock stays open");
  key_open_hi_a: assert property ( // [R16]
    (r.unhi == 2'h2 && r.aw_ok && r.w_ok) |=> r.unhi == 2'h0) else $error("high lock stays open");

endmodule // cswfs_top

// ---- sim/clock_switch_failsafe_reset_tb.sv ----
// Purpose: self-checking bench of the clock switch and reset block
// Assumes: short power-up counts 20/40/80 cycles, 100 MHz clock
// Notes: every wait is bounded; a timeout counts as a mismatch
`timescale 1ns/1ps
`include "cswfs_regs.svh"
module clock_switch_failsafe_reset_tb import cswfs_pkg::*;;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  localparam int POR = 1000;
  localparam int PW1 = 20;
  logic clk_i = 0;
  logic rstn_i = 0;
  cswfs_pins_t pins;
  cswfs_cfg_t cfg = '0;
  cswfs_core_t core = '0;
  logic osc_on = 1, fail = 0, pin_n = 1, bo = 0, trap_seen = 0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, ce = 1;
  logic [1:0] wresp = '0;
  logic awready, wready, bvalid, arready, rvalid, sys_rst, slow_en, trap;
  logic [1:0] bresp, rresp, grp;
  logic [3:0] psel;
  logic [31:0] rdata;
  int n_mismatch = 0;
  int checks = 0;
  always #5 clk_i = ~clk_i;
  // the trap is a one-cycle pulse, so keep a sticky copy
  always @(posedge clk_i) begin
    if (rstn_i === 1'b0) begin
      trap_seen <= 1'b0;
    end else if (trap === 1'b1) begin
      trap_seen <= 1'b1;
    end
  end
  cswfs_osc_model cswfs_osc_model_inst (.clk_i(clk_i), .osc_on_i(osc_on), .fail_i(fail),
    .pin_n_i(pin_n), .brownout_i(bo), .pins_o(pins));
  cswfs_top #(.PWRT1_CYC(PW1), .PWRT2_CYC(40), .PWRT3_CYC(80)) cswfs_top_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .pins_i(pins), .cfg_i(cfg), .core_i(core),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .system_reset_o(sys_rst), .slow_osc_en_o(slow_en), .sys_clk_grp_o(grp),
    .primary_sel_o(psel), .clock_fail_trap_o(trap));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic hang(input string what);
    chk(what, 32'h1, 32'h0);
    test_done();
  endtask
  // both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    logic aw_open;
    logic w_open;
    aw_open = 1;
    w_open = 1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if (aw_open && awready === 1'b1) begin
        aw_open = 0;
        awvalid <= 0;
      end
      if (w_open && wready === 1'b1) begin
        w_open = 0;
        wvalid <= 0;
      end
      if (bvalid === 1'b1) begin
        wresp = bresp;
        break;
      end
    end
    bready <= 0;
    if (n == 40) hang("write answer");
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if (rvalid === 1'b1) break;
      if (arready === 1'b1) arvalid <= 0;
    end
    d = rdata;
    r = rresp;
    rready <= 0;
    if (n == 40) hang("read answer");
    @(posedge clk_i);
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(what, e, d & m);
  endtask
  task automatic wait_rst(input logic lvl, input int lim, output int c);
    for (c = 0; c < lim && sys_rst !== lvl; c++) @(posedge clk_i);
    if (c == lim) hang("reset level");
  endtask
  task automatic boot(input logic [1:0] smc, input logic [1:0] pw, input logic on);
    cfg <= '{osc_source_cfg: 3'h3, primary_osc_cfg: 4'h5, switch_monitor_cfg: smc,
             powerup_cfg: pw, wdt_cfg_en: 1'b0};
    osc_on <= on;
    rstn_i <= 0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_power_up();
    int c;
    logic [31:0] d;
    logic [1:0] r;
    boot(2'h0, 2'h1, 1'b1);
    wait_rst(1'b0, 3000, c);
    chk("release time", 32'h1, 32'(c >= POR + PW1 && c <= POR + PW1 + 16));
    rchk("osc control", `CSWFS_OSC_CTRL_OFS, 32'h3328, 32'h3320);
    rchk("reset cause", `CSWFS_CAUSE_OFS, 32'hff, 32'h03);
    chk("primary mode", 32'h5, 32'(psel));
    wr(`CSWFS_MISC_OFS, 32'h0, 4'hf);
    chk("slow osc kept", 32'h1, 32'(slow_en));
    core.sleep <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("slow osc in sleep", 32'h0, 32'(slow_en));
    core.sleep <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(8'h40, d, r);
    chk("unmapped resp", 32'h2, 32'(r));
    wr(8'h40, 32'h0, 4'hf);
    chk("unmapped write", 32'h2, 32'(wresp));
  endtask
  task automatic t_switch();
    int n;
    wr(`CSWFS_OSC_CTRL_OFS, 32'h0100, 4'h2);
    rchk("new group locked", `CSWFS_OSC_CTRL_OFS, 32'h300, 32'h300);
    wr(`CSWFS_OSC_CTRL_OFS, {16'h0, `CSWFS_KEY_HI1, 8'h0}, 4'h2);
    wr(`CSWFS_OSC_CTRL_OFS, {16'h0, `CSWFS_KEY_HI2, 8'h0}, 4'h2);
    wr(`CSWFS_OSC_CTRL_OFS, 32'h0, 4'h2);
    rchk("new group", `CSWFS_OSC_CTRL_OFS, 32'h3300, 32'h3000);
    wr(`CSWFS_OSC_CTRL_OFS, {24'h0, `CSWFS_KEY_LO1}, 4'h1);
    wr(`CSWFS_OSC_CTRL_OFS, {24'h0, `CSWFS_KEY_LO2}, 4'h1);
    wr(`CSWFS_OSC_CTRL_OFS, 32'h1, 4'h1);
    // enable low holds the switch count part-way
    ce <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk("frozen group", 32'h3, 32'(grp));
    ce <= 1'b1;
    for (n = 0; n < 20 && grp !== 2'h0; n++) @(posedge clk_i);
    chk("switched group", 32'h0, 32'(grp));
    rchk("switch done", `CSWFS_OSC_CTRL_OFS, 32'h3001, 32'h0);
  endtask
  task automatic t_fail();
    int n;
    fail <= 1;
    for (n = 0; n < 20 && trap_seen !== 1'b1; n++) @(posedge clk_i);
    fail <= 0;
    repeat (2) @(posedge clk_i);
    chk("fail trap", 32'h1, 32'(trap_seen));
    chk("fast group", 32'(`CSWFS_GRP_FAST), 32'(grp));
    rchk("fail status", `CSWFS_OSC_CTRL_OFS, 32'h3009, 32'h1008);
    chk("watchdog clock", 32'h1, 32'(slow_en));
  endtask
  task automatic t_resets();
    int c;
    logic [7:0] e;
    wr(`CSWFS_CAUSE_OFS, 32'h0, 4'hf);
    pin_n <= 0;
    repeat (4) @(posedge clk_i);
    pin_n <= 1;
    repeat (6) @(posedge clk_i);
    chk("short pin pulse", 32'h0, 32'(sys_rst));
    pin_n <= 0;
    repeat (20) @(posedge clk_i);
    chk("pin reset", 32'h1, 32'(sys_rst));
    pin_n <= 1;
    wait_rst(1'b0, 60, c);
    rchk("pin cause", `CSWFS_CAUSE_OFS, 32'hff, 32'h20);
    // reset instruction, trap lockup, illegal operation in turn
    for (int k = 0; k < 3; k++) begin
      e = (k == 0) ? 8'h10 : (k == 1) ? 8'h80 : 8'h40;
      wr(`CSWFS_CAUSE_OFS, 32'h0, 4'hf);
      core <= '{sleep: 1'b0, wdt_timeout: 1'b0, reset_instr: k == 0, trap_lockup: k == 1,
                illegal_op: k == 2};
      @(posedge clk_i);
      core <= '0;
      wait_rst(1'b1, 20, c);
      wait_rst(1'b0, 60, c);
      rchk("core cause", `CSWFS_CAUSE_OFS, 32'hff, 32'(e));
    end
    wr(`CSWFS_CAUSE_OFS, 32'h0, 4'hf);
    core <= '{sleep: 1'b1, wdt_timeout: 1'b1, default: 1'b0};
    @(posedge clk_i);
    core <= '0;
    repeat (6) @(posedge clk_i);
    chk("wake no reset", 32'h0, 32'(sys_rst));
    rchk("wake cause", `CSWFS_CAUSE_OFS, 32'hff, 32'h0c);
    bo <= 1;
    repeat (5) @(posedge clk_i);
    bo <= 0;
    wait_rst(1'b0, 3000, c);
    rchk("brownout cause", `CSWFS_CAUSE_OFS, 32'h01, 32'h01);
    rchk("groups reloaded", `CSWFS_OSC_CTRL_OFS, 32'h3300, 32'h3300);
  endtask
  task automatic t_late_osc();
    int c;
    boot(2'h0, 2'h1, 1'b0);
    wait_rst(1'b0, 3000, c);
    repeat (3) @(posedge clk_i);
    chk("late osc trap", 32'h1, 32'(trap_seen));
    chk("late osc group", 32'(`CSWFS_GRP_FAST), 32'(grp));
  endtask
  task automatic t_no_monitor();
    int c;
    boot(2'h2, 2'h0, 1'b0);
    repeat (1500) @(posedge clk_i);
    chk("frozen in reset", 32'h1, 32'(sys_rst));
    osc_on <= 1;
    wait_rst(1'b0, 60, c);
    chk("quick exit", 32'h1, 32'(c < 40));
    wr(`CSWFS_MISC_OFS, 32'h0, 4'hf);
    chk("slow osc off", 32'h0, 32'(slow_en));
    wr(`CSWFS_MISC_OFS, 32'h1, 4'hf);
    chk("slow osc for watchdog", 32'h1, 32'(slow_en));
    fail <= 1;
    repeat (12) @(posedge clk_i);
    fail <= 0;
    chk("no trap", 32'h0, 32'(trap_seen));
    chk("fixed group", 32'h3, 32'(grp));
    rchk("group reported", `CSWFS_OSC_CTRL_OFS, 32'h3000, 32'h3000);
  endtask
  initial begin
    t_power_up();
    t_switch();
    t_fail();
    t_resets();
    t_late_osc();
    t_no_monitor();
    test_done();
  end
endmodule // clock_switch_failsafe_reset_tb

// ---- sim/cswfs_osc_model.sv ----
// Purpose: oscillator sources and reset pins seen by the clock switch block
// Assumes: the bench commands power, failure and pin levels
// Notes: start-up and lock times are short stand-ins for real crystals
`timescale 1ns/1ps
module cswfs_osc_model import cswfs_pkg::*; #(
  parameter int START_CYC = 30,
  parameter int LOCK_CYC = 60
) (
  input wire logic clk_i,
  input wire logic osc_on_i,
  input wire logic fail_i,
  input wire logic pin_n_i,
  input wire logic brownout_i,
  output wire cswfs_pins_t pins_o
);
  // ------------------------------------------------------------
  // start-up ageing
  // ------------------------------------------------------------
  int age = 0;
  // a stopped or failed source restarts its warm-up from zero
  always @(posedge clk_i) begin
    if (!osc_on_i || fail_i) begin
      age <= 0;
    end else if (age < LOCK_CYC) begin
      age <= age + 1;
    end
  end
  // no slow clocks
  // a failed source stops outright, it never crawls below the monitor floor
  assign pins_o.osc_running = osc_on_i && !fail_i;
  assign pins_o.osc_fail = fail_i;
  assign pins_o.osc_startup_done = pins_o.osc_running && age >= START_CYC;
  assign pins_o.pll_lock = pins_o.osc_running && age >= LOCK_CYC;
  // pins pass straight through; the block synchronises them itself
  assign pins_o.ext_reset_pin_n = pin_n_i;
  assign pins_o.brownout = brownout_i;
endmodule // cswfs_osc_model
